// [shared/bfh_params.svh]
`ifndef BFH_PARAMS_SVH
`define BFH_PARAMS_SVH
// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define BFH_ADDR_W        18
`define BFH_DATA_W        8
// ---------------------------------------------------------------
// Timing (ns) and clock
// ---------------------------------------------------------------
`define BFH_CLK_PERIOD_NS 100
`define BFH_ACCESS_NS     70
`define BFH_STROBE_NS     100
`define BFH_RESET_NS      500
`define BFH_CYC(ns) (((ns) + `BFH_CLK_PERIOD_NS - 1) / `BFH_CLK_PERIOD_NS)
`define BFH_ACCESS_CYC    `BFH_CYC(`BFH_ACCESS_NS)
`define BFH_STROBE_CYC    `BFH_CYC(`BFH_STROBE_NS)
`define BFH_RESET_CYC     `BFH_CYC(`BFH_RESET_NS)
`define BFH_CNT_W         4
`define BFH_SYNC_CYC      2
// ---------------------------------------------------------------
// Sector boundaries, upper five address bits
// ---------------------------------------------------------------
`define BFH_TOP_S1        5'h08
`define BFH_TOP_S2        5'h10
`define BFH_TOP_S3        5'h18
`define BFH_TOP_S4        5'h1C
`define BFH_TOP_S5        5'h1D
`define BFH_TOP_S6        5'h1E
`define BFH_BOT_S1        5'h02
`define BFH_BOT_S2        5'h03
`define BFH_BOT_S3        5'h04
`define BFH_BOT_S4        5'h08
`define BFH_BOT_S5        5'h10
`define BFH_BOT_S6        5'h18
`endif

// [shared/bfh_pkg.sv]
package bfh_pkg;
    typedef enum logic [1:0] {
        BFH_OP_READ,
        BFH_OP_WRITE,
        BFH_OP_RESET
    } bfh_op_t;
    typedef logic [2:0] bfh_sector_t;
endpackage

// [core/bfh_sector_map.sv]
`timescale 1ns/100ps
`include "bfh_params.svh"
module bfh_sector_map (
    input  wire logic [4:0]  upper_bits,   // Address bits 17..13
    input  wire logic        bottom_boot,  // 1 for bottom-boot map
    output logic [2:0]       sector_idx    // Sector 0..6
);
    // ---------------------------------------------------------------
    // Sector decode
    // ---------------------------------------------------------------
    // Boundary compare only; the low address bits never matter
    always_comb begin
        sector_idx = 3'h0;
        if (bottom_boot) begin
            if (upper_bits >= `BFH_BOT_S6) sector_idx = 3'h6; // R16
            else if (upper_bits >= `BFH_BOT_S5) sector_idx = 3'h5;
            else if (upper_bits >= `BFH_BOT_S4) sector_idx = 3'h4;
            else if (upper_bits >= `BFH_BOT_S3) sector_idx = 3'h3;
            else if (upper_bits >= `BFH_BOT_S2) sector_idx = 3'h2;
            else if (upper_bits >= `BFH_BOT_S1) sector_idx = 3'h1;
        end else begin
            if (upper_bits >= `BFH_TOP_S6) sector_idx = 3'h6; // R15
            else if (upper_bits >= `BFH_TOP_S5) sector_idx = 3'h5;
            else if (upper_bits >= `BFH_TOP_S4) sector_idx = 3'h4;
            else if (upper_bits >= `BFH_TOP_S3) sector_idx = 3'h3;
            else if (upper_bits >= `BFH_TOP_S2) sector_idx = 3'h2;
            else if (upper_bits >= `BFH_TOP_S1) sector_idx = 3'h1;
        end
    end
endmodule

// [core/bfh_host.sv]
// Contract
// R1 - Read: select and gate low, strobe high
// R2 - Write: strobe and select low, gate high
// R3 - Device floats data while gate high
// R4 - Device floats data in standby
// R5 - Select high means standby
// R6 - Wait full access time after standby
// R7 - Deselect never aborts running operation
// R8 - Reset and power-up give array read
// R9 - Array read persists until a write
// R10 - Long enough reset aborts, floats data
// R11 - Bus ignored while reset low
// R12 - Reissue operations a reset interrupted
// R13 - Autoselect reads give identification codes
// R14 - Busy device reads return status
// R15 - Top-boot seven-sector address map
// R16 - Bottom-boot seven-sector address map
// R17 - Sector chosen by its address bits
// R18 - Command register has no address
// R19 - High voltage reset means unprotect
// R20 - Address at last fall, data first rise
// R21 - Bad write returns to array read
// R22 - Running operation ignores reset command
// R23 - 18-bit address, 8-bit data bus
`timescale 1ns/100ps
`include "bfh_params.svh"
module bfh_host #(
    parameter int ADDR_W = `BFH_ADDR_W,
    parameter int DATA_W = `BFH_DATA_W
) (
    input  wire logic              sys_clk,      // 10 MHz clock
    input  wire logic              nrst,         // Sync reset, low
    input  wire logic              req_valid,    // Request present
    output logic                   req_ready,    // Request accepted
    input  wire bfh_pkg::bfh_op_t  req_op,       // Read/write/reset
    input  wire logic [ADDR_W-1:0] req_addr,     // Byte address
    input  wire logic [DATA_W-1:0] req_wdata,    // Write data
    input  wire logic              bottom_boot,  // Map choice
    output logic                   rsp_valid,    // One-cycle done
    output logic [DATA_W-1:0]      rsp_rdata,    // Read data
    output logic [2:0]             rsp_sector,   // Sector of request
    output logic                   retry_hint,   // Reset hit a write
    output logic [ADDR_W-1:0]      byte_address_lines, // Address pins
    output logic [DATA_W-1:0]      byte_data_lines_o,  // Data drive
    output logic                   byte_data_lines_oe, // Drive enable
    input  wire logic [DATA_W-1:0] byte_data_lines_i,  // Data sense
    output logic                   chip_sel_n,   // Chip select, low
    output logic                   out_gate_n,   // Output gate, low
    output logic                   wr_strobe_n,  // Write strobe, low
    output logic                   dev_reset_n   // Device reset, low
);
    // ---------------------------------------------------------------
    // State and counters
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD, ST_WR, ST_WR_END, ST_RST
    } bfh_state_t;
    bfh_state_t             state_q;
    logic [`BFH_CNT_W-1:0]  cnt_q;
    logic [DATA_W-1:0]      sync1_q;
    logic [DATA_W-1:0]      sync2_q;
    logic                   wrote_q;
    logic [2:0]             sector_w;
    logic                   cnt_done;

    // Shared down-count step; the cast keeps the width exact
    function automatic logic [`BFH_CNT_W-1:0] cnt_dec(
        input logic [`BFH_CNT_W-1:0] c  // Current count
    );
        return c - `BFH_CNT_W'(1);
    endfunction

    assign cnt_done  = (cnt_q == '0);
    assign req_ready = (state_q == ST_IDLE);

    // Sector of the request, for the caller's erase bookkeeping
    bfh_sector_map u_map (
        .upper_bits  (req_addr[ADDR_W-1:ADDR_W-5]), // R17
        .bottom_boot (bottom_boot),
        .sector_idx  (sector_w)
    );

    // Data pins pass two flops before use
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= byte_data_lines_i;
            sync2_q <= sync1_q;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // Each cycle starts from standby, so a read always waits the
    // full select access time plus synchroniser latency
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        unique case (req_op)
                            bfh_pkg::BFH_OP_READ: begin
                                state_q <= ST_RD;
                                cnt_q <= `BFH_CNT_W'(`BFH_ACCESS_CYC
                                         + `BFH_SYNC_CYC); // R6
                            end
                            bfh_pkg::BFH_OP_WRITE: begin
                                state_q <= ST_WR;
                                cnt_q <= `BFH_CNT_W'(`BFH_STROBE_CYC);
                            end
                            default: begin
                                state_q <= ST_RST;
                                cnt_q <= `BFH_CNT_W'(`BFH_RESET_CYC); // R10
                            end
                        endcase
                    end
                end
                ST_RD: begin
                    if (cnt_done) state_q <= ST_IDLE;
                    else cnt_q <= cnt_dec(cnt_q);
                end
                ST_WR: begin
                    if (cnt_done) state_q <= ST_WR_END;
                    else cnt_q <= cnt_dec(cnt_q);
                end
                ST_WR_END: state_q <= ST_IDLE;
                ST_RST: begin
                    if (cnt_done) state_q <= ST_IDLE;
                    else cnt_q <= cnt_dec(cnt_q);
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin drive, registered
    // ---------------------------------------------------------------
    // Gate held high during writes so device never drives back
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            chip_sel_n         <= 1'b1;
            out_gate_n         <= 1'b1;
            wr_strobe_n        <= 1'b1;
            dev_reset_n        <= 1'b1;
            byte_data_lines_oe <= 1'b0;
            byte_data_lines_o  <= '0;
            byte_address_lines <= '0;
        end else begin
            chip_sel_n  <= 1'b1; // R5
            out_gate_n  <= 1'b1;
            wr_strobe_n <= 1'b1;
            dev_reset_n <= 1'b1;
            byte_data_lines_oe <= 1'b0;
            if (state_q == ST_IDLE && req_valid) begin
                byte_address_lines <= req_addr; // R23
                byte_data_lines_o  <= req_wdata;
                unique case (req_op)
                    bfh_pkg::BFH_OP_READ: begin
                        chip_sel_n <= 1'b0; // R1
                        out_gate_n <= 1'b0;
                    end
                    bfh_pkg::BFH_OP_WRITE: begin
                        chip_sel_n  <= 1'b0; // R2
                        wr_strobe_n <= 1'b0; // R20
                        byte_data_lines_oe <= 1'b1;
                    end
                    default: dev_reset_n <= 1'b0;
                endcase
            end else if (state_q == ST_RD && !cnt_done) begin
                chip_sel_n <= 1'b0;
                out_gate_n <= 1'b0;
            end else if (state_q == ST_WR) begin
                // Strobe and select rise together; data held two cycles longer
                chip_sel_n  <= cnt_done;
                wr_strobe_n <= cnt_done; // R20
                byte_data_lines_oe <= 1'b1;
            end else if (state_q == ST_WR_END) begin
                byte_data_lines_oe <= 1'b1;
            end else if (state_q == ST_RST && !cnt_done) begin
                dev_reset_n <= 1'b0; // R11
            end
        end
    end

    // ---------------------------------------------------------------
    // Answers
    // ---------------------------------------------------------------
    // Read data may be array, id or status: caller interprets it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rsp_valid  <= 1'b0;
            rsp_rdata  <= '0;
            rsp_sector <= 3'h0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == ST_IDLE && req_valid) rsp_sector <= sector_w;
            if (state_q == ST_RD && cnt_done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= sync2_q; // R13 R14
            end
            if ((state_q == ST_WR_END) || (state_q == ST_RST && cnt_done))
                rsp_valid <= 1'b1;
        end
    end

    // Flag that a reset may have cut a program or erase short
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wrote_q    <= 1'b0;
            retry_hint <= 1'b0;
        end else if (state_q == ST_WR_END) begin
            wrote_q    <= 1'b1;
            retry_hint <= 1'b0;
        end else if (state_q == ST_RST && cnt_done) begin
            retry_hint <= wrote_q; // R12
            wrote_q    <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_read_ctl;
        @(posedge sys_clk) disable iff (!nrst)
        !out_gate_n |-> (!chip_sel_n && wr_strobe_n && !byte_data_lines_oe);
    endproperty
    a_read_ctl: assert property (p_read_ctl) // R1
        else $error("read controls wrong");
    property p_write_ctl;
        @(posedge sys_clk) disable iff (!nrst)
        !wr_strobe_n |-> (!chip_sel_n && out_gate_n && byte_data_lines_oe);
    endproperty
    a_write_ctl: assert property (p_write_ctl) // R2
        else $error("write controls wrong");
    property p_access_wait;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(out_gate_n) |-> !out_gate_n [*3];
    endproperty
    a_access_wait: assert property (p_access_wait) // R6
        else $error("read gate too short");
    property p_data_hold;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(wr_strobe_n) |-> byte_data_lines_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) // R20
        else $error("data dropped at strobe rise");
    property p_reset_quiet;
        @(posedge sys_clk) disable iff (!nrst)
        !dev_reset_n |-> (chip_sel_n && out_gate_n && wr_strobe_n);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) // R11
        else $error("bus active during reset");
    property p_reset_len;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(dev_reset_n) |-> !dev_reset_n [*5];
    endproperty
    a_reset_len: assert property (p_reset_len) // R10
        else $error("reset pulse too short");
endmodule

// [tb/bfh_flash_model.sv]
`timescale 1ns/100ps
module bfh_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h5A, // Arbitrary identification value
    parameter int         ACC_NS  = 70,    // Access time after select
    parameter int         RP_NS   = 500,   // reset_pulse_min_time
    parameter logic [7:0] GO_CODE = 8'hC3, // Arbitrary start-operation byte
    parameter logic [7:0] STAT_CODE = 8'h3C, // Arbitrary busy status value
    parameter int         BUSY_NS = 4000   // Length of a running operation
) (
    input  wire logic [17:0] byte_address_lines, // Address pins
    input  wire logic [7:0]  host_d,             // Host data drive
    input  wire logic        host_oe,            // Host drives data
    input  wire logic        chip_sel_n,         // Chip select, low
    input  wire logic        out_gate_n,         // Output gate, low
    input  wire logic        wr_strobe_n,        // Write strobe, low
    input  wire logic        dev_reset_n,        // Device reset, low
    output logic [7:0]       line_d              // Resolved data wire
);
    // -----------------------------------------------------------
    // Read path, command latch and hardware reset
    // -----------------------------------------------------------
    logic       id_mode_q;
    logic       busy_q;
    realtime    t_go;
    logic       sel_rd;
    logic       rd_ok;
    logic       wr_act;
    logic [7:0] dev_d;
    logic [7:0] last_v;
    realtime    t_rst;
    // Drives only on a clean read cycle, never in standby or reset
    assign sel_rd = !chip_sel_n && !out_gate_n && wr_strobe_n && dev_reset_n;
    assign #(ACC_NS) rd_ok = sel_rd;
    // A running operation answers every read with its status
    assign dev_d = busy_q    ? STAT_CODE
                 : id_mode_q ? ID_CODE
                 : byte_address_lines[7:0]
                   ^ {2'b00, byte_address_lines[17:12]};
    // Released wire shows the inverse of its last level, not a copy
    always @* begin
        if (host_oe)
            last_v = host_d;
        else if (sel_rd && rd_ok)
            last_v = dev_d;
    end
    assign line_d = host_oe ? host_d : (sel_rd && rd_ok) ? dev_d : ~last_v;
    assign wr_act = !chip_sel_n && !wr_strobe_n && out_gate_n;
    // Data taken on the first rising strobe; any other byte aborts
    // Writes are dropped while an operation runs, reset bytes too;
    // case equality keeps the unknown pins of time zero harmless
    initial id_mode_q = 1'b0;
    initial busy_q    = 1'b0;
    always @(negedge wr_act) begin
        if (dev_reset_n === 1'b1 && !busy_q) begin
            id_mode_q <= (line_d === 8'h90);
            busy_q    <= (line_d === GO_CODE);
            t_go       = $realtime;
        end
    end
    // Timer runs on with select high: deselect never pauses it
    always begin
        #10;
        if (busy_q && $realtime - t_go >= BUSY_NS)
            busy_q <= 1'b0;
    end
    // A pulse shorter than the minimum is not honoured; the pin only
    // sees logic levels, so the unprotect level never arrives here
    always @(negedge dev_reset_n) t_rst = $realtime;
    always @(posedge dev_reset_n) begin
        if ($realtime - t_rst >= RP_NS) begin
            id_mode_q <= 1'b0;
            busy_q    <= 1'b0;
        end
    end
endmodule

// [tb/bfh_host_bench.sv]
`timescale 1ns/100ps
module bfh_host_bench;
    // -----------------------------------------------------------
    // Stimulus, partner and checks
    // -----------------------------------------------------------
    localparam logic [7:0] ID = 8'hA5; // Arbitrary identification value
    localparam logic [7:0] GO   = 8'hC3; // Arbitrary start-operation byte
    localparam logic [7:0] STAT = 8'h3C; // Arbitrary busy status value
    logic             sys_clk     = 1'b0;
    logic             nrst        = 1'b0;
    logic             req_valid   = 1'b0;
    logic             bottom_boot = 1'b0;
    bfh_pkg::bfh_op_t req_op      = bfh_pkg::BFH_OP_READ;
    logic [17:0]      req_addr    = 18'h0_0000;
    logic [7:0]       req_wdata   = 8'h00;
    logic             req_ready, rsp_valid, retry_hint, d_oe;
    logic             cs_n, og_n, we_n, rs_n;
    logic [17:0]      a_pins;
    logic [7:0]       rsp_rdata, d_o, d_line;
    logic [2:0]       rsp_sector;
    int               error_cnt = 0;
    int               n_checks  = 0;
    int               cyc       = 0;
    always #50 sys_clk = ~sys_clk;
    bfh_host i_dut (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .bottom_boot(bottom_boot),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sector(rsp_sector),
        .retry_hint(retry_hint), .byte_address_lines(a_pins),
        .byte_data_lines_o(d_o), .byte_data_lines_oe(d_oe),
        .byte_data_lines_i(d_line), .chip_sel_n(cs_n), .out_gate_n(og_n),
        .wr_strobe_n(we_n), .dev_reset_n(rs_n));
    bfh_flash_model #(.ID_CODE(ID), .GO_CODE(GO), .STAT_CODE(STAT))
        i_dev (.byte_address_lines(a_pins),
        .host_d(d_o), .host_oe(d_oe), .chip_sel_n(cs_n), .out_gate_n(og_n),
        .wr_strobe_n(we_n), .dev_reset_n(rs_n), .line_d(d_line));
    function automatic logic [7:0] patt(input logic [17:0] a);
        return a[7:0] ^ {2'b00, a[17:12]};
    endfunction
    task automatic give_verdict;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Request held until the edge that takes it, then bounded wait
    task automatic do_req(input bfh_pkg::bfh_op_t op, input logic [17:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check({7'h00, rsp_valid}, 8'h01, "response");
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] e,
                      input logic [2:0] s);
        do_req(bfh_pkg::BFH_OP_READ, a, 8'h00);
        check(rsp_rdata, e, "read data");
        check({5'h00, rsp_sector}, {5'h00, s}, "sector");
    endtask
    // Array reads straight after reset, top-boot boundaries
    task automatic t_top_map;
        logic [17:0] a [7] = '{18'h0_FFFF, 18'h1_0000, 18'h2_ABCD,
            18'h3_7FFF, 18'h3_8000, 18'h3_A000, 18'h3_C000};
        bottom_boot = 1'b0;
        for (int i = 0; i < 7; i++) rd(a[i], patt(a[i]), 3'(i));
    endtask
    task automatic t_bottom_map;
        logic [17:0] a [7] = '{18'h0_3FFF, 18'h0_4000, 18'h0_6000,
            18'h0_8000, 18'h1_0000, 18'h2_0000, 18'h3_FFFF};
        bottom_boot = 1'b1;
        for (int i = 0; i < 7; i++) rd(a[i], patt(a[i]), 3'(i));
    endtask
    // Identification mode at any address, left by a stray byte
    task automatic t_id_mode;
        do_req(bfh_pkg::BFH_OP_WRITE, 18'h0_0555, 8'h90);
        rd(18'h0_0000, ID, 3'h0);
        rd(18'h3_C123, ID, 3'h6);
        do_req(bfh_pkg::BFH_OP_WRITE, 18'h0_0000, 8'h33);
        rd(18'h1_2345, patt(18'h1_2345), 3'h4);
    endtask
    // Status while busy, stray write ignored, reset pulse cuts it
    task automatic t_reset_op;
        do_req(bfh_pkg::BFH_OP_WRITE, 18'h0_0555, 8'h90);
        do_req(bfh_pkg::BFH_OP_WRITE, 18'h0_0555, GO);
        rd(18'h1_0000, STAT, 3'h4);
        do_req(bfh_pkg::BFH_OP_WRITE, 18'h0_0000, 8'hF0);
        rd(18'h1_0000, STAT, 3'h4);
        do_req(bfh_pkg::BFH_OP_RESET, 18'h0_0000, 8'h00);
        check({7'h00, retry_hint}, 8'h01, "retry set");
        rd(18'h2_0001, patt(18'h2_0001), 3'h5);
        do_req(bfh_pkg::BFH_OP_WRITE, 18'h0_0000, 8'hF0);
        check({7'h00, retry_hint}, 8'h00, "retry clear");
    endtask
    // Mid-run reset leaves pins idle, then reads work again
    task automatic t_sys_reset;
        nrst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({2'b00, cs_n, og_n, we_n, rs_n, d_oe, req_ready}, 8'h3D,
              "idle pins");
        nrst = 1'b1;
        rd(18'h3_0042, patt(18'h3_0042), 3'h6);
    endtask
    // Strobe combinations must stay legal, no bus fight on reads
    always @(negedge sys_clk) begin
        if (nrst) begin
            n_checks++;
            if (!og_n && (cs_n || !we_n || d_oe)) begin
                error_cnt++;
                $display("ERROR %0t: bad read strobes", $time);
            end
            if (!we_n && (cs_n || !og_n)) begin
                error_cnt++;
                $display("ERROR %0t: bad write strobes", $time);
            end
        end
    end
    // Hang guard, far above the expected few hundred cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("ERROR %0t: timeout", $time);
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        t_top_map();
        t_bottom_map();
        t_id_mode();
        t_reset_op();
        t_sys_reset();
        give_verdict();
    end
endmodule
